// ---- logic/mpsm_cfg.svh ----
/*
 * Offsets, field positions, reset values and timing counts for the
 * memory controller power state manager.
 * Assumes inclusion by bare name from the logic/ folder.
 */
`ifndef MPSM_CFG_SVH
`define MPSM_CFG_SVH

`define MPSM_OFF_ID        8'h00
`define MPSM_OFF_ASYNC_CFG 8'h04
`define MPSM_OFF_SDCFG     8'h08
`define MPSM_OFF_REFRESH   8'h0c
`define MPSM_OFF_STATUS    8'h10

`define MPSM_ID_VALUE      32'h5a5a_0001 // Arbitrary module id

`define MPSM_SDCFG_SR_BIT  31
`define MPSM_SDCFG_PD_BIT  30
`define MPSM_SDCFG_RST     32'h0000_0000

`define MPSM_AC_SETUP_LSB  0
`define MPSM_AC_STROBE_LSB 4
`define MPSM_AC_HOLD_LSB   10
`define MPSM_AC_TA_LSB     14
`define MPSM_AC_MAXW_LSB   16
`define MPSM_AC_WIDE_BIT   24
`define MPSM_ASYNC_RST     32'h0080_0000

`define MPSM_REFRESH_RST   32'h0000_0186

`define MPSM_FILL_WORDS    4'h8
`define MPSM_MAX_WORDS     5'h10
`define MPSM_CYC_PER_WORD8 3'h4
`define MPSM_MAX_CYC8      7'h40

`endif

// ---- logic/mpsm_pkg.sv ----
/*
 * Types shared by the power state manager.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package mpsm_pkg;
    typedef enum logic [1:0] {
        MPSM_PWR_ENABLE,
        MPSM_PWR_AUTO_SLEEP,
        MPSM_PWR_AUTO_WAKE,
        MPSM_PWR_SYNC_RESET
    } mpsm_pwr_t;

    typedef enum logic [3:0] {
        MPSM_MS_IDLE,
        MPSM_MS_REFRESH,
        MPSM_MS_PD_REFRESH,
        MPSM_MS_FILL,
        MPSM_MS_SETUP,
        MPSM_MS_STROBE,
        MPSM_MS_HOLD,
        MPSM_MS_TURN,
        MPSM_MS_SELF_REFRESH
    } mpsm_mem_t;
endpackage

`default_nettype wire

// ---- logic/mpsm_sync.sv ----
/*
 * Two flip-flop level synchroniser, one per bit.
 * Assumes the input is asynchronous to clk_in.
 */
`timescale 1ns/100ps
`default_nettype none

module mpsm_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // mpsm_sync

`default_nettype wire

// ---- logic/mpsm_top.sv ----
/*
 * Power and state manager of an external memory controller: power-down
 * clock enable, self-refresh entry after draining work, module clock
 * states from the power sleep controller, cache-fill blocking and
 * asynchronous access cycle timing with wait extension.
 * Assumes one request presented at a time by an outside arbiter, and a
 * power sleep controller that sequences self-refresh around clock stop.
 */
`timescale 1ns/100ps
`default_nettype none
`include "mpsm_cfg.svh"

module mpsm_top #(
    parameter int WORDS_W = 5
) (
    input  wire logic               clk_in,
    input  wire logic               rst_in,
    input  wire logic [7:0]         reg_addr_in,
    input  wire logic [31:0]        reg_wdata_in,
    input  wire logic [3:0]         reg_be_in,
    input  wire logic               reg_wr_in,
    input  wire logic               reg_rd_in,
    output logic      [31:0]        reg_rdata_out,
    output logic                    reg_ack_out,
    input  wire logic [1:0]         pwr_state_in,
    output logic [1:0]              pwr_state_out,
    input  wire logic               mem_req_in,
    input  wire logic               mem_wr_in,
    input  wire logic               mem_sdram_in,
    input  wire logic [WORDS_W-1:0] mem_words_in,
    output logic                    mem_done_out,
    output logic                    mem_refused_out,
    input  wire logic               fill_req_in,
    output logic                    fill_word_out,
    output logic                    fill_done_out,
    input  wire logic               refresh_due_in,
    input  wire logic               external_wait_input,
    output logic                    sdram_clock_enable_pin,
    output logic                    auto_refresh_command,
    output logic                    self_refresh_active_out,
    output logic                    async_strobe_out
);
    ////////////////////////////////////////////////////////////////////
    // Registers and state
    logic [31:0]         sdcfg_r;
    logic [31:0]         async_cfg_r;
    logic [3:0]          backlog_r;
    logic                sr_enter;
    mpsm_pkg::mpsm_pwr_t pwr_r;
    mpsm_pkg::mpsm_mem_t ms_r;
    logic                awake_r;
    logic [6:0]          cyc_left_r;
    logic [WORDS_W-1:0]  words_r;
    logic [7:0]          tcnt_r;
    logic [7:0]          wait_cnt_r;
    logic                wr_r;
    logic                sdram_r;
    logic                wait_sync;
    logic                pwr_hold;
    logic                take_req;
    logic                sr_req;
    logic                pd_req;

    assign sr_req = sdcfg_r[`MPSM_SDCFG_SR_BIT];
    assign pd_req = sdcfg_r[`MPSM_SDCFG_PD_BIT];

    mpsm_sync #(
        .WIDTH(1)
    ) u_wait_sync (
        .clk_in  (clk_in),
        .rst_in  (rst_in),
        .async_in(external_wait_input),
        .sync_out(wait_sync)
    );

    ////////////////////////////////////////////////////////////////////
    // Module clock state from the power sleep controller
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pwr_r <= mpsm_pkg::MPSM_PWR_ENABLE;
        end else begin
            pwr_r <= mpsm_pkg::mpsm_pwr_t'(pwr_state_in);
        end
    end

    // Auto sleep wakes for a request and drops back after it
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            awake_r <= 1'b1;
        end else if (pwr_r == mpsm_pkg::MPSM_PWR_AUTO_SLEEP) begin
            awake_r <= take_req || (ms_r != mpsm_pkg::MPSM_MS_IDLE &&
                       ms_r != mpsm_pkg::MPSM_MS_SELF_REFRESH);
        end else begin
            awake_r <= 1'b1;
        end
    end

    assign pwr_state_out = (pwr_r == mpsm_pkg::MPSM_PWR_AUTO_SLEEP &&
                            awake_r) ? 2'(mpsm_pkg::MPSM_PWR_ENABLE)
                                     : 2'(pwr_r);
    assign pwr_hold = (pwr_r == mpsm_pkg::MPSM_PWR_SYNC_RESET);

    ////////////////////////////////////////////////////////////////////
    // Register port; sync reset leaves registers untouched
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sdcfg_r <= `MPSM_SDCFG_RST;
        end else if (reg_wr_in && !pwr_hold &&
                     reg_addr_in == `MPSM_OFF_SDCFG) begin
            for (int b = 0; b < 4; b++) begin
                if (reg_be_in[b]) begin
                    sdcfg_r[b*8 +: 8] <= reg_wdata_in[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            async_cfg_r <= `MPSM_ASYNC_RST;
        end else if (reg_wr_in && !pwr_hold &&
                     reg_addr_in == `MPSM_OFF_ASYNC_CFG) begin
            async_cfg_r <= reg_wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 32'h0000_0000;
            reg_ack_out   <= 1'b0;
        end else begin
            reg_ack_out   <= reg_rd_in && !pwr_hold;
            reg_rdata_out <= 32'h0000_0000;
            if (reg_rd_in && !pwr_hold) begin
                unique case (reg_addr_in)
                    `MPSM_OFF_ID:        reg_rdata_out <= `MPSM_ID_VALUE;
                    `MPSM_OFF_ASYNC_CFG: reg_rdata_out <= async_cfg_r;
                    `MPSM_OFF_SDCFG:     reg_rdata_out <= sdcfg_r;
                    `MPSM_OFF_STATUS:    reg_rdata_out <= {20'h00000,
                        sdram_r, wr_r, backlog_r, ms_r, self_refresh_active_out,
                        sdram_clock_enable_pin};
                    default:             reg_rdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Refresh backlog counter
    logic refresh_done;
    assign refresh_done = (ms_r == mpsm_pkg::MPSM_MS_REFRESH) ||
                          (ms_r == mpsm_pkg::MPSM_MS_PD_REFRESH);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            backlog_r <= 4'h0;
        end else if (ms_r == mpsm_pkg::MPSM_MS_SELF_REFRESH) begin
            backlog_r <= 4'h0;
        end else if (refresh_due_in && !refresh_done && backlog_r != 4'hf) begin
            backlog_r <= backlog_r + 4'h1;
        end else if (!refresh_due_in && refresh_done && backlog_r != 4'h0) begin
            backlog_r <= backlog_r - 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Memory sequencer
    assign take_req = mem_req_in && !fill_req_in && !pwr_hold &&
                      mem_words_in != '0 &&
                      mem_words_in <= WORDS_W'(`MPSM_MAX_WORDS);

    // Idle with nothing left to do: self-refresh is taken on the next edge
    assign sr_enter = ms_r == mpsm_pkg::MPSM_MS_IDLE && !pwr_hold &&
                      !fill_req_in && backlog_r == 4'h0 && !take_req &&
                      sr_req;

    assign mem_refused_out = mem_req_in && !pwr_hold &&
                             ms_r == mpsm_pkg::MPSM_MS_IDLE &&
                             (mem_words_in == '0 ||
                              mem_words_in > WORDS_W'(`MPSM_MAX_WORDS));

    logic [6:0] req_cycles;
    assign req_cycles = async_cfg_r[`MPSM_AC_WIDE_BIT]
        ? 7'({mem_words_in, 1'b0})
        : 7'({mem_words_in, 2'b00});

    logic [7:0] max_wait;
    assign max_wait = async_cfg_r[`MPSM_AC_MAXW_LSB +: 8];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ms_r       <= mpsm_pkg::MPSM_MS_IDLE;
            cyc_left_r <= 7'h00;
            words_r    <= '0;
            tcnt_r     <= 8'h00;
            wait_cnt_r <= 8'h00;
            wr_r       <= 1'b0;
            sdram_r    <= 1'b0;
        end else begin
            unique case (ms_r)
                mpsm_pkg::MPSM_MS_IDLE: begin
                    if (pwr_hold) begin
                        ms_r <= mpsm_pkg::MPSM_MS_IDLE;
                    end else if (fill_req_in) begin
                        ms_r    <= mpsm_pkg::MPSM_MS_FILL;
                        words_r <= WORDS_W'(`MPSM_FILL_WORDS);
                    end else if (backlog_r >= 4'h8) begin
                        ms_r <= mpsm_pkg::MPSM_MS_REFRESH;
                    end else if (take_req) begin
                        wr_r       <= mem_wr_in;
                        sdram_r    <= mem_sdram_in;
                        cyc_left_r <= req_cycles;
                        tcnt_r     <= 8'(async_cfg_r[`MPSM_AC_SETUP_LSB +: 4]);
                        ms_r       <= mpsm_pkg::MPSM_MS_SETUP;
                    end else if (backlog_r != 4'h0) begin
                        ms_r <= pd_req ? mpsm_pkg::MPSM_MS_PD_REFRESH
                                       : mpsm_pkg::MPSM_MS_REFRESH;
                    end else if (sr_req) begin
                        ms_r <= mpsm_pkg::MPSM_MS_SELF_REFRESH;
                    end
                end
                mpsm_pkg::MPSM_MS_REFRESH,
                mpsm_pkg::MPSM_MS_PD_REFRESH: begin
                    ms_r <= mpsm_pkg::MPSM_MS_IDLE;
                end
                mpsm_pkg::MPSM_MS_FILL: begin
                    words_r <= words_r - WORDS_W'(1);
                    if (words_r == WORDS_W'(1)) begin
                        ms_r <= mpsm_pkg::MPSM_MS_IDLE;
                    end
                end
                mpsm_pkg::MPSM_MS_SETUP: begin
                    if (tcnt_r == 8'h00) begin
                        tcnt_r     <= 8'(async_cfg_r[`MPSM_AC_STROBE_LSB +: 6]);
                        wait_cnt_r <= 8'h00;
                        ms_r       <= mpsm_pkg::MPSM_MS_STROBE;
                    end else begin
                        tcnt_r <= tcnt_r - 8'h01;
                    end
                end
                mpsm_pkg::MPSM_MS_STROBE: begin
                    if (wait_sync && wait_cnt_r < max_wait) begin
                        wait_cnt_r <= wait_cnt_r + 8'h01;
                    end else if (tcnt_r == 8'h00) begin
                        tcnt_r <= 8'(async_cfg_r[`MPSM_AC_HOLD_LSB +: 3]);
                        ms_r   <= mpsm_pkg::MPSM_MS_HOLD;
                    end else begin
                        tcnt_r <= tcnt_r - 8'h01;
                    end
                end
                mpsm_pkg::MPSM_MS_HOLD: begin
                    if (tcnt_r == 8'h00) begin
                        tcnt_r <= 8'(async_cfg_r[`MPSM_AC_TA_LSB +: 2]);
                        ms_r   <= mpsm_pkg::MPSM_MS_TURN;
                    end else begin
                        tcnt_r <= tcnt_r - 8'h01;
                    end
                end
                mpsm_pkg::MPSM_MS_TURN: begin
                    if (tcnt_r != 8'h00) begin
                        tcnt_r <= tcnt_r - 8'h01;
                    end else if (cyc_left_r <= 7'h01) begin
                        ms_r <= mpsm_pkg::MPSM_MS_IDLE;
                    end else begin
                        cyc_left_r <= cyc_left_r - 7'h01;
                        tcnt_r <= 8'(async_cfg_r[`MPSM_AC_SETUP_LSB +: 4]);
                        ms_r   <= mpsm_pkg::MPSM_MS_SETUP;
                    end
                end
                mpsm_pkg::MPSM_MS_SELF_REFRESH: begin
                    if (!pwr_hold && (take_req || fill_req_in)) begin
                        ms_r <= mpsm_pkg::MPSM_MS_IDLE;
                    end else if (!sr_req && !pwr_hold) begin
                        ms_r <= mpsm_pkg::MPSM_MS_IDLE;
                    end
                end
                default: ms_r <= mpsm_pkg::MPSM_MS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sdram_clock_enable_pin <= 1'b1;
        end else if (sr_enter ||
                     ms_r == mpsm_pkg::MPSM_MS_SELF_REFRESH) begin
            sdram_clock_enable_pin <= 1'b0;
        end else if (pd_req) begin
            sdram_clock_enable_pin <= take_req || fill_req_in ||
                (ms_r == mpsm_pkg::MPSM_MS_IDLE &&
                 backlog_r != 4'h0) ||
                (ms_r != mpsm_pkg::MPSM_MS_IDLE &&
                 ms_r != mpsm_pkg::MPSM_MS_PD_REFRESH);
        end else begin
            sdram_clock_enable_pin <= 1'b1;
        end
    end

    assign auto_refresh_command    = refresh_done;
    assign self_refresh_active_out = (ms_r == mpsm_pkg::MPSM_MS_SELF_REFRESH);
    assign async_strobe_out        = (ms_r == mpsm_pkg::MPSM_MS_STROBE);
    assign fill_word_out           = (ms_r == mpsm_pkg::MPSM_MS_FILL);
    assign fill_done_out = (ms_r == mpsm_pkg::MPSM_MS_FILL) &&
                           (words_r == WORDS_W'(1));
    assign mem_done_out  = (ms_r == mpsm_pkg::MPSM_MS_TURN) &&
                           tcnt_r == 8'h00 && cyc_left_r <= 7'h01;
endmodule // mpsm_top

`default_nettype wire

// ---- verification/mpsm_checker.sv ----
/* Port assertions for the power state manager.
   Assumes binding onto mpsm_top, one clock, rst_in synchronous high. */
`timescale 1ns/100ps
`default_nettype none
module mpsm_checker #(
    parameter int WORDS_W = 5
) (
    input wire logic               clk_in,
    input wire logic               rst_in,
    input wire logic               reg_rd_in,
    input wire logic               reg_ack_out,
    input wire logic [1:0]         pwr_state_in,
    input wire logic [1:0]         pwr_state_out,
    input wire logic               mem_req_in,
    input wire logic [WORDS_W-1:0] mem_words_in,
    input wire logic               mem_refused_out,
    input wire logic               fill_word_out,
    input wire logic               fill_done_out,
    input wire logic               sdram_clock_enable_pin,
    input wire logic               auto_refresh_command,
    input wire logic               self_refresh_active_out,
    input wire logic               async_strobe_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    AST_RD_ACK: assert property (reg_rd_in && pwr_state_in != 2'h3 &&
        $past(pwr_state_in) != 2'h3 |=> reg_ack_out)
        else $error("read not acknowledged");
    AST_ACK_CAUSE: assert property (reg_ack_out |-> $past(reg_rd_in))
        else $error("acknowledge without read");
    AST_SYNC_REFUSE: assert property ((pwr_state_in == 2'h3)[*2]
        |=> !reg_ack_out) else $error("register served in sync reset");
    AST_PD_REFRESH: assert property (auto_refresh_command
        |-> sdram_clock_enable_pin) else $error("refresh with clock off");
    AST_SR_CKE: assert property (self_refresh_active_out
        |-> !sdram_clock_enable_pin) else $error("clock on in self refresh");
    AST_SR_IDLE: assert property (self_refresh_active_out |->
        !async_strobe_out && !fill_word_out && !auto_refresh_command)
        else $error("work during self refresh");
    AST_FILL_LEN: assert property ($rose(fill_word_out) |->
        (fill_word_out && !fill_done_out)[*7] ##1
        (fill_word_out && fill_done_out)) else $error("fill not 8 words");
    AST_FILL_HOLD: assert property (fill_word_out
        |-> !async_strobe_out) else $error("access during fill");
    AST_SIZE: assert property (mem_req_in && mem_words_in > 16
        |-> mem_refused_out) else $error("oversize request taken");
    AST_ENABLE: assert property ((pwr_state_in == 2'h0)[*2]
        |-> pwr_state_out == 2'h0) else $error("not in enable state");
endmodule // mpsm_checker

bind mpsm_top mpsm_checker #(.WORDS_W(WORDS_W)) chk_u (
    .clk_in(clk_in), .rst_in(rst_in), .reg_rd_in(reg_rd_in),
    .reg_ack_out(reg_ack_out), .pwr_state_in(pwr_state_in),
    .pwr_state_out(pwr_state_out), .mem_req_in(mem_req_in),
    .mem_words_in(mem_words_in), .mem_refused_out(mem_refused_out),
    .fill_word_out(fill_word_out), .fill_done_out(fill_done_out),
    .sdram_clock_enable_pin(sdram_clock_enable_pin),
    .auto_refresh_command(auto_refresh_command),
    .self_refresh_active_out(self_refresh_active_out),
    .async_strobe_out(async_strobe_out)
);
`default_nettype wire

// ---- verification/mpsm_mem_model.sv ----
/* Asynchronous memory device answering the strobe with its wait line.
   Assumes it shares clk_in with the design. */
`timescale 1ns/100ps
`default_nettype none
module mpsm_mem_model (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic slow_in,
    input  wire logic async_strobe_in,
    output logic      external_wait_out
);
    // Slow device holds wait through the strobe; idle line pulled inactive
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            external_wait_out <= 1'b0;
        end else begin
            external_wait_out <= slow_in && async_strobe_in;
        end
    end
endmodule // mpsm_mem_model
`default_nettype wire

// ---- verification/mpsm_top_tb_top.sv ----
/* Self-checking bench for the power state manager.
   Assumes mpsm_pkg and mpsm_cfg.svh are compiled and on the include path. */
`timescale 1ns/100ps
`default_nettype none
`include "mpsm_cfg.svh"
module mpsm_top_tb_top;
    logic        clk_in, rst_in, reg_wr_in, reg_rd_in, reg_ack_out, slow;
    logic [7:0]  reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, d;
    logic [3:0]  reg_be_in;
    logic [1:0]  pwr_state_in, pwr_state_out;
    logic        mem_req_in, mem_wr_in, mem_sdram_in, mem_done_out;
    logic        mem_refused_out, fill_req_in, fill_word_out, fill_done_out;
    logic        refresh_due_in, external_wait_input, sdram_clock_enable_pin;
    logic        auto_refresh_command, self_refresh_active_out;
    logic        async_strobe_out, ack, sr_early;
    logic [4:0]  mem_words_in;
    int          failures, num_checks, st, fw, n_ref, n;

    mpsm_top dut_u (.clk_in(clk_in), .rst_in(rst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_be_in(reg_be_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out),
        .pwr_state_in(pwr_state_in), .pwr_state_out(pwr_state_out),
        .mem_req_in(mem_req_in), .mem_wr_in(mem_wr_in),
        .mem_sdram_in(mem_sdram_in), .mem_words_in(mem_words_in),
        .mem_done_out(mem_done_out), .mem_refused_out(mem_refused_out),
        .fill_req_in(fill_req_in), .fill_word_out(fill_word_out),
        .fill_done_out(fill_done_out), .refresh_due_in(refresh_due_in),
        .external_wait_input(external_wait_input),
        .sdram_clock_enable_pin(sdram_clock_enable_pin),
        .auto_refresh_command(auto_refresh_command),
        .self_refresh_active_out(self_refresh_active_out),
        .async_strobe_out(async_strobe_out));
    mpsm_mem_model mem_u (.clk_in(clk_in), .rst_in(rst_in), .slow_in(slow),
        .async_strobe_in(async_strobe_out),
        .external_wait_out(external_wait_input));

    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [3:0] be);
        @(posedge clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= v;
        reg_be_in    <= be;
        reg_wr_in    <= 1'b1;
        @(posedge clk_in);
        reg_wr_in    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clk_in);
        reg_rd_in   <= 1'b0;
        @(negedge clk_in);
        d   = reg_rdata_out;
        ack = reg_ack_out;
    endtask

    task automatic rdc(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
        rd(a);
        check(what, d, exp);
        check("ack", ack, 1'b1);
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk_in);
    endtask

    task automatic pulse_refresh();
        @(posedge clk_in);
        refresh_due_in <= 1'b1;
        @(posedge clk_in);
        refresh_due_in <= 1'b0;
    endtask

    // Holds the request until done, counting strobe and fill cycles
    task automatic mem_run(input logic [4:0] w, input logic f);
        logic fd;
        fd = 1'b0;
        st = 0;
        fw = 0;
        @(posedge clk_in);
        mem_req_in   <= 1'b1;
        mem_words_in <= w;
        fill_req_in  <= f;
        for (int i = 0; i < 3000; i++) begin
            @(negedge clk_in);
            if (async_strobe_out) st++;
            if (fill_word_out) fw++;
            if (fill_done_out) fd = 1'b1;
            if (mem_done_out) break;
            @(posedge clk_in);
            if (fd) fill_req_in <= 1'b0;
        end
        check("mem done", mem_done_out, 1'b1);
        @(posedge clk_in);
        mem_req_in  <= 1'b0;
        fill_req_in <= 1'b0;
    endtask

    always @(negedge clk_in) begin
        if (auto_refresh_command) n_ref++;
        if (self_refresh_active_out && mem_req_in) sr_early = 1'b1;
    end

    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        failures++;
        end_of_test();
    end

    initial begin
        rst_in = 1'b1;
        {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
        {reg_be_in, pwr_state_in, mem_req_in, mem_wr_in, mem_sdram_in} = '0;
        {mem_words_in, fill_req_in, refresh_due_in, slow, sr_early} = '0;
        tick(5);
        rst_in <= 1'b0;
        check("state", pwr_state_out, mpsm_pkg::MPSM_PWR_ENABLE);
        rdc("id", `MPSM_OFF_ID, `MPSM_ID_VALUE);
        rdc("sdcfg", `MPSM_OFF_SDCFG, `MPSM_SDCFG_RST);
        wr(`MPSM_OFF_ASYNC_CFG, 32'h0002_4451, 4'hf);
        rdc("async cfg", `MPSM_OFF_ASYNC_CFG, 32'h0002_4451);
        mem_run(5'h10, 1'b0);
        check("strobes 8-bit", st, 384);
        @(posedge clk_in);
        mem_req_in   <= 1'b1;
        mem_words_in <= 5'h11;
        @(negedge clk_in);
        check("refused", mem_refused_out, 1'b1);
        @(posedge clk_in);
        mem_req_in <= 1'b0;
        wr(`MPSM_OFF_ASYNC_CFG, 32'h0102_4451, 4'hf);
        mem_run(5'h10, 1'b0);
        check("strobes 16-bit", st, 192);
        wr(`MPSM_OFF_ASYNC_CFG, 32'h0002_4451, 4'hf);
        slow <= 1'b1;
        mem_run(5'h01, 1'b0);
        check("wait bounded", st > 24 && st <= 32, 1'b1);
        slow <= 1'b0;
        mem_run(5'h01, 1'b1);
        check("fill first", fw, 8);
        wr(`MPSM_OFF_SDCFG, 32'h4000_0000, 4'b1000);
        tick(10);
        check("cke pd", sdram_clock_enable_pin, 1'b0);
        pulse_refresh();
        n_ref = 0;
        for (n = 0; n < 100 && !auto_refresh_command; n++) @(negedge clk_in);
        check("cke refresh", sdram_clock_enable_pin, 1'b1);
        tick(10);
        check("cke pd again", sdram_clock_enable_pin, 1'b0);
        rdc("sdcfg pd", `MPSM_OFF_SDCFG, 32'h4000_0000);
        wr(`MPSM_OFF_SDCFG, 32'h0, 4'b1000);
        n_ref = 0;
        fork
            mem_run(5'h02, 1'b0);
            begin
                repeat (3) pulse_refresh();
                wr(`MPSM_OFF_SDCFG, 32'h8000_0000, 4'b1000);
            end
        join
        for (n = 0; n < 500 && !self_refresh_active_out; n++) @(negedge clk_in);
        check("sr entered", self_refresh_active_out, 1'b1);
        check("sr refreshes", n_ref, 3);
        check("sr early", sr_early, 1'b0);
        @(posedge clk_in);
        pwr_state_in <= 2'h3;
        tick(3);
        wr(`MPSM_OFF_ASYNC_CFG, 32'h0, 4'hf);
        rd(`MPSM_OFF_ASYNC_CFG);
        check("sync ack", ack, 1'b0);
        @(posedge clk_in);
        mem_req_in   <= 1'b1;
        mem_words_in <= 5'h01;
        st = 0;
        repeat (60) @(negedge clk_in) if (mem_done_out || async_strobe_out) st++;
        check("sync mem", st, 0);
        @(posedge clk_in);
        mem_req_in   <= 1'b0;
        pwr_state_in <= 2'h0;
        tick(3);
        rdc("kept async", `MPSM_OFF_ASYNC_CFG, 32'h0002_4451);
        rdc("kept sdcfg", `MPSM_OFF_SDCFG, 32'h8000_0000);
        @(posedge clk_in);
        pwr_state_in <= 2'h1;
        tick(3);
        check("sleep", pwr_state_out, mpsm_pkg::MPSM_PWR_AUTO_SLEEP);
        mem_run(5'h01, 1'b0);
        tick(5);
        check("sleep back", pwr_state_out, 2'h1);
        pwr_state_in <= 2'h2;
        wr(`MPSM_OFF_SDCFG, 32'h0, 4'b1000);
        tick(5);
        check("sr left", self_refresh_active_out, 1'b0);
        check("awake", pwr_state_out == 2'h1, 1'b0);
        pwr_state_in <= 2'h0;
        tick(3);
        end_of_test();
    end
endmodule // mpsm_top_tb_top
`default_nettype wire
